// >>> rtl/pavdr_aux_port.v
// Auxiliary three-pin output port: serial, static and idle drive
`timescale 1ns/100ps
`include "pavdr_defines.vh"
module pavdr_aux_port #(
    parameter PINS = 3
) (
    input  wire            clk_i,
    input  wire            rst_b_i,
    input  wire            port_en_i,
    input  wire            serial_mode_i,
    input  wire [PINS-1:0] static_val_i,
    input  wire [1:0]      route_i,
    input  wire [1:0]      idle_i,
    input  wire            gpo_bit_i,
    input  wire [PINS-1:0] serial_pins_i,
    output wire [PINS-1:0] pin_o,
    output wire [PINS-1:0] pin_oe_o
);

    reg [PINS-1:0] pin_q;
    reg [PINS-1:0] oe_q;

    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1) begin : g_pin
            wire routed;
            assign routed = (route_i != `PAVDR_RTE_NONE) && (route_i == g + 1);
            always @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    pin_q[g] <= 1'b0;
                    oe_q[g]  <= 1'b0;
                end else if (!port_en_i) begin
                    case (idle_i)
                        `PAVDR_IDL_HIZ: begin
                            oe_q[g] <= 1'b0;
                        end
                        `PAVDR_IDL_HOLD: begin
                            oe_q[g] <= 1'b1;
                        end
                        `PAVDR_IDL_HIGH: begin
                            pin_q[g] <= 1'b1;
                            oe_q[g]  <= 1'b1;
                        end
                        default: begin
                            pin_q[g] <= 1'b0;
                            oe_q[g]  <= 1'b1;
                        end
                    endcase
                end else begin
                    oe_q[g] <= 1'b1;
                    if (routed) begin
                        pin_q[g] <= gpo_bit_i;
                    end else if (serial_mode_i) begin
                        pin_q[g] <= serial_pins_i[g];
                    end else begin
                        pin_q[g] <= static_val_i[g];
                    end
                end
            end
        end
    endgenerate

    assign pin_o    = pin_q;
    assign pin_oe_o = oe_q;

endmodule // pavdr_aux_port

// >>> rtl/pavdr_regs.v
// Register slice: serial access, auxiliary port, oscillator and divider controls
`timescale 1ns/100ps
`include "pavdr_defines.vh"
module pavdr_regs #(
    parameter AUX_PINS = 3
) (
    input  wire                clk_i,
    input  wire                rst_b_i,
    // Serial register interface, sampled on clk_i
    input  wire                ser_clk_i,
    input  wire                ser_en_i,
    input  wire                ser_di_i,
    output wire                ser_do_o,
    // Device status
    input  wire [18:0]         cal_error_mag_i,
    input  wire                cal_error_neg_i,
    input  wire                lock_detect_i,
    input  wire [31:0]         gpo_sources_i,
    input  wire                exact_freq_en_i,
    input  wire                chip_en_i,
    // Auxiliary port
    input  wire                aux_port_en_i,
    input  wire [AUX_PINS-1:0] aux_serial_pins_i,
    output wire [AUX_PINS-1:0] aux_pin_o,
    output wire [AUX_PINS-1:0] aux_pin_oe_o,
    output wire                aux_level_3v3_o,
    output wire                general_output_mux_o,
    output wire                phase_sync_trig_o,
    // Oscillator manual controls
    output wire                manual_cal_o,
    output wire [4:0]          cap_switch_o,
    output wire [2:0]          subband_o,
    output wire                manual_tune_o,
    output wire                charge_pump_autoscale_o,
    // Divider and gain
    output wire [5:0]          div_ratio_o,
    output wire                out_mute_o,
    output wire [1:0]          osc_output_one_gain_o,
    output wire [1:0]          osc_output_two_gain_o,
    output wire                div_stage_gain_o,
    output wire [23:0]         mod_seed_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame capture

    reg        sclk_prev_q;
    reg        sen_prev_q;
    reg [4:0]  bit_cnt_q;
    reg        rd_q;
    reg [`PAVDR_ADDR_W-1:0] addr_q;
    reg [`PAVDR_DATA_W-1:0] wdata_q;
    reg [`PAVDR_DATA_W-1:0] rshift_q;
    reg        sdo_q;
    reg        hdr_load_q;

    wire sclk_rise;
    wire sclk_fall;
    wire frame_end;
    wire hdr_done;
    wire wr_commit;
    reg  [`PAVDR_DATA_W-1:0] rd_data;

    assign sclk_rise = ser_en_i && ser_clk_i && !sclk_prev_q;
    assign sclk_fall = ser_en_i && !ser_clk_i && sclk_prev_q;
    assign frame_end = sen_prev_q && !ser_en_i;
    assign hdr_done  = sclk_rise && (bit_cnt_q == `PAVDR_HDR_BITS - 5'd1);
    assign wr_commit = frame_end && !rd_q && (bit_cnt_q == `PAVDR_FRAME_BITS);

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sclk_prev_q <= 1'b0;
            sen_prev_q  <= 1'b0;
            bit_cnt_q   <= 5'h00;
            rd_q        <= 1'b0;
            addr_q      <= {`PAVDR_ADDR_W{1'b0}};
            wdata_q     <= {`PAVDR_DATA_W{1'b0}};
            hdr_load_q  <= 1'b0;
        end else begin
            sclk_prev_q <= ser_clk_i;
            sen_prev_q  <= ser_en_i;
            hdr_load_q  <= hdr_done;
            // Rises past the frame length neither count nor shift
            if (!ser_en_i) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_rise) begin
                if (bit_cnt_q != `PAVDR_FRAME_BITS) begin
                    bit_cnt_q <= bit_cnt_q + 5'd1;
                end
                if (bit_cnt_q == 5'h00) begin
                    rd_q <= ser_di_i;
                end else if (bit_cnt_q < `PAVDR_HDR_BITS) begin
                    addr_q <= {addr_q[`PAVDR_ADDR_W-2:0], ser_di_i};
                end else if (bit_cnt_q != `PAVDR_FRAME_BITS) begin
                    wdata_q <= {wdata_q[`PAVDR_DATA_W-2:0], ser_di_i};
                end
            end
        end
    end

    // Address is complete only after the 7th rise, so the read word
    // loads one cycle later and shifts out on falling serial clock
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rshift_q <= {`PAVDR_DATA_W{1'b0}};
            sdo_q    <= 1'b0;
        end else if (hdr_load_q) begin
            rshift_q <= rd_data;
        end else if (sclk_fall && rd_q && (bit_cnt_q >= `PAVDR_HDR_BITS)) begin
            sdo_q    <= rshift_q[`PAVDR_DATA_W-1];
            rshift_q <= {rshift_q[`PAVDR_DATA_W-2:0], 1'b0};
        end else if (!ser_en_i) begin
            sdo_q <= 1'b0;
        end
    end

    assign ser_do_o = sdo_q;

    ////////////////////////////////////////////////////////////////////////////
    // Writable registers

    reg [`PAVDR_DATA_W-1:0] gpo_sel_q;
    reg [`PAVDR_DATA_W-1:0] aux_ctrl_q;
    reg [`PAVDR_DATA_W-1:0] man_osc_q;
    reg [`PAVDR_DATA_W-1:0] div_gain_q;
    reg [`PAVDR_DATA_W-1:0] seed_q;

    // Whole words stored, reserved bits included; read-only offsets ignored
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gpo_sel_q  <= `PAVDR_RST_GPO_SEL;
            aux_ctrl_q <= `PAVDR_RST_AUX_CTRL;
            man_osc_q  <= `PAVDR_RST_MAN_OSC;
            div_gain_q <= `PAVDR_RST_DIV_GAIN;
            seed_q     <= `PAVDR_RST_SEED;
        end else if (wr_commit) begin
            case (addr_q)
                `PAVDR_A_GPO_SEL: begin
                    gpo_sel_q <= wdata_q;
                end
                `PAVDR_A_AUX_CTRL: begin
                    aux_ctrl_q <= wdata_q;
                end
                `PAVDR_A_MAN_OSC: begin
                    man_osc_q <= wdata_q;
                end
                `PAVDR_A_DIV_GAIN: begin
                    div_gain_q <= wdata_q;
                end
                `PAVDR_A_SEED: begin
                    seed_q <= wdata_q;
                end
                // Read-only and unmapped offsets change nothing
                default: begin
                    seed_q <= seed_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General output mux and read mux

    wire [4:0] gpo_sel;
    reg        gpo_q;

    assign gpo_sel = gpo_sel_q[`PAVDR_GPO_SEL_HI:`PAVDR_GPO_SEL_LO];

    // Selected source registered before pins and readback
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gpo_q <= 1'b0;
        end else begin
            gpo_q <= gpo_sources_i[gpo_sel];
        end
    end

    assign general_output_mux_o = gpo_q;

    // Read word follows the completed address
    always @* begin
        case (addr_q)
            `PAVDR_A_GPO_SEL: begin
                rd_data = gpo_sel_q;
            end
            `PAVDR_A_CAL_ERR: begin
                rd_data = {4'h0, cal_error_neg_i, cal_error_mag_i};
            end
            `PAVDR_A_OUT_LOCK: begin
                rd_data = {22'h000000, lock_detect_i, gpo_q};
            end
            `PAVDR_A_SELF_TEST: begin
                rd_data = `PAVDR_SELF_TEST_VAL;
            end
            `PAVDR_A_AUX_CTRL: begin
                rd_data = aux_ctrl_q;
            end
            `PAVDR_A_MAN_OSC: begin
                rd_data = man_osc_q;
            end
            `PAVDR_A_DIV_GAIN: begin
                rd_data = div_gain_q;
            end
            `PAVDR_A_SEED: begin
                rd_data = seed_q;
            end
            default: begin
                rd_data = {`PAVDR_DATA_W{1'b0}};
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auxiliary port

    pavdr_aux_port #(
        .PINS (AUX_PINS)
    ) u_aux (
        .clk_i         (clk_i),
        .rst_b_i       (rst_b_i),
        .port_en_i     (aux_port_en_i),
        .serial_mode_i (aux_ctrl_q[`PAVDR_AUX_SER_BIT]),
        .static_val_i  (aux_ctrl_q[`PAVDR_AUX_VAL_HI:`PAVDR_AUX_VAL_LO]),
        .route_i       (aux_ctrl_q[`PAVDR_AUX_RTE_HI:`PAVDR_AUX_RTE_LO]),
        .idle_i        (aux_ctrl_q[`PAVDR_AUX_IDL_HI:`PAVDR_AUX_IDL_LO]),
        .gpo_bit_i     (gpo_q),
        .serial_pins_i (aux_serial_pins_i),
        .pin_o         (aux_pin_o),
        .pin_oe_o      (aux_pin_oe_o)
    );

    // Level select only matters in static mode; serial mode keeps 1.8 V
    assign aux_level_3v3_o = aux_ctrl_q[`PAVDR_AUX_LVL_BIT] && !aux_ctrl_q[`PAVDR_AUX_SER_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Phase sync trigger from chip enable rising edge

    reg  chip_en_prev_q;
    reg  sync_trig_q;
    wire chip_en_rise;

    // Chip enable taken as synchronous; edge found on clk_i
    assign chip_en_rise = chip_en_i && !chip_en_prev_q;

    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            chip_en_prev_q <= 1'b0;
            sync_trig_q    <= 1'b0;
        end else begin
            chip_en_prev_q <= chip_en_i;
            sync_trig_q    <= chip_en_rise && exact_freq_en_i
                              && aux_ctrl_q[`PAVDR_AUX_SYNC_BIT];
        end
    end

    assign phase_sync_trig_o = sync_trig_q;
    assign mod_seed_o        = seed_q;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator manual controls

    assign manual_cal_o            = man_osc_q[`PAVDR_MAN_CAL_BIT];
    assign cap_switch_o            = man_osc_q[`PAVDR_MAN_CAP_HI:`PAVDR_MAN_CAP_LO];
    assign subband_o               = man_osc_q[`PAVDR_MAN_SUB_HI:`PAVDR_MAN_SUB_LO];
    assign manual_tune_o           = man_osc_q[`PAVDR_MAN_TUNE_BIT];
    assign charge_pump_autoscale_o = man_osc_q[`PAVDR_MAN_SCL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Divide ratio resolution and gains

    wire [5:0] div_raw;
    wire       div_mute;
    reg  [5:0] div_q;
    reg        mute_q;

    assign div_raw  = div_gain_q[`PAVDR_DIV_RAT_HI:`PAVDR_DIV_RAT_LO];
    assign div_mute = (div_raw == `PAVDR_DIV_MUTE);

    // Odd codes other than 1 round down to even, codes above the top ratio clamp
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_q  <= `PAVDR_DIV_ONE;
            mute_q <= 1'b0;
        end else begin
            mute_q <= div_mute;
            if (div_mute) begin
                div_q <= `PAVDR_DIV_MUTE;
            end else if (div_raw == `PAVDR_DIV_ONE) begin
                div_q <= `PAVDR_DIV_ONE;
            end else if (div_raw > `PAVDR_DIV_MAX) begin
                div_q <= `PAVDR_DIV_MAX;
            end else begin
                div_q <= {div_raw[5:1], 1'b0};
            end
        end
    end

    assign div_ratio_o           = div_q;
    assign out_mute_o            = mute_q;
    assign osc_output_one_gain_o = div_gain_q[`PAVDR_DIV_G1_HI:`PAVDR_DIV_G1_LO];
    assign osc_output_two_gain_o = div_gain_q[`PAVDR_DIV_G2_HI:`PAVDR_DIV_G2_LO];
    assign div_stage_gain_o      = div_gain_q[`PAVDR_DIV_STG_BIT];

endmodule // pavdr_regs

// >>> shared/pavdr_defines.vh
// Constants for the synthesizer auxiliary, oscillator and divider register slice
// Contract
// - Calibration error readback: 19-bit magnitude low, sign bit 19, 1 negative.
// - Serial mode bit 1 runs auxiliary pins as serial port, else static.
// - Static mode drives each auxiliary pin from its value field bit.
// - Level select bit picks 1.8 V when 0, 3.3 V when 1; the code keeps 1.8 V in serial mode.
// - Phase sync bit makes chip enable a sync trigger; needs exact mode; resets 1.
// - Routing field sends general output to none, pin 0, pin 1 or pin 2.
// - Disabled port state: 0 high impedance, 1 hold, 2 high, 3 low.
// - Manual calibration mode bit enables manual calibration; resets 0.
// - Manual config holds 5-bit capacitor setting (16) and 3-bit sub-band (2).
// - Manual tune enable bit turns manual tuning on; resets 0.
// - Auto-scale bit 1 scales charge pump current automatically; resets 1.
// - Divide field: 0 mutes, 1 undivided, even 2 to 62 divide.
// - Odd divide values use next lower even ratio; above 62 uses 62.
// - Two 2-bit buffer gain fields: code 3 maximum, 3 dB per step down.
// - Divider output stage gain bit: 1 maximum, 0 is 3 dB lower.
// - A 5-bit source field selects the general output signal.
// - 24-bit modulator seed sets output phase for phase stepping.
`ifndef PAVDR_DEFINES_VH
`define PAVDR_DEFINES_VH

// Serial frame: read flag, 6-bit address, 24-bit data, MSB first
`define PAVDR_FRAME_BITS    5'd31
`define PAVDR_HDR_BITS      5'd7
`define PAVDR_ADDR_W        6
`define PAVDR_DATA_W        24

// Register offsets
`define PAVDR_A_GPO_SEL     6'h0f
`define PAVDR_A_CAL_ERR     6'h11
`define PAVDR_A_OUT_LOCK    6'h12
`define PAVDR_A_SELF_TEST   6'h13
`define PAVDR_A_AUX_CTRL    6'h14
`define PAVDR_A_MAN_OSC     6'h15
`define PAVDR_A_DIV_GAIN    6'h16
`define PAVDR_A_SEED        6'h1a

// Reset values
`define PAVDR_RST_GPO_SEL   24'h000001
`define PAVDR_RST_AUX_CTRL  24'h000220
`define PAVDR_RST_MAN_OSC   24'h0f48a0
`define PAVDR_RST_DIV_GAIN  24'h0006c1
`define PAVDR_RST_SEED      24'hb29d0b
`define PAVDR_SELF_TEST_VAL 24'h001259

// Field positions
`define PAVDR_GPO_SEL_HI    4
`define PAVDR_GPO_SEL_LO    0
`define PAVDR_AUX_SER_BIT   0
`define PAVDR_AUX_VAL_HI    3
`define PAVDR_AUX_VAL_LO    1
`define PAVDR_AUX_LVL_BIT   4
`define PAVDR_AUX_SYNC_BIT  9
`define PAVDR_AUX_RTE_HI    11
`define PAVDR_AUX_RTE_LO    10
`define PAVDR_AUX_IDL_HI    13
`define PAVDR_AUX_IDL_LO    12
`define PAVDR_MAN_CAL_BIT   0
`define PAVDR_MAN_CAP_HI    5
`define PAVDR_MAN_CAP_LO    1
`define PAVDR_MAN_SUB_HI    8
`define PAVDR_MAN_SUB_LO    6
`define PAVDR_MAN_TUNE_BIT  9
`define PAVDR_MAN_SCL_BIT   16
`define PAVDR_DIV_RAT_HI    5
`define PAVDR_DIV_RAT_LO    0
`define PAVDR_DIV_G1_HI     7
`define PAVDR_DIV_G1_LO     6
`define PAVDR_DIV_G2_HI     9
`define PAVDR_DIV_G2_LO     8
`define PAVDR_DIV_STG_BIT   10
`define PAVDR_CAL_SIGN_BIT  19

// Divide ratio limits
`define PAVDR_DIV_MUTE      6'h00
`define PAVDR_DIV_ONE       6'h01
`define PAVDR_DIV_MAX       6'h3e

// Routing and idle codes
`define PAVDR_RTE_NONE      2'h0
`define PAVDR_IDL_HIZ       2'h0
`define PAVDR_IDL_HOLD      2'h1
`define PAVDR_IDL_HIGH      2'h2
`define PAVDR_IDL_LOW       2'h3

`endif

// >>> testbench/pavdr_host.sv
// Host controller model on the serial register interface
`timescale 1ns/100ps
module pavdr_host (
    input  wire clk_i,
    input  wire ser_do_i,
    output reg  ser_clk_o,
    output reg  ser_en_o,
    output reg  ser_di_o
);
    initial begin
        ser_clk_o = 1'b0;
        ser_en_o  = 1'b0;
        ser_di_o  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    // Frame of n bits, MSB first; read data taken before each rise after the 7th
    task xfer(input rd, input [5:0] a, input [23:0] wd, input integer n, output reg [23:0] q);
        reg [30:0] f;
        integer    i;
        begin
            f = {rd, a, wd};
            q = 24'h0;
            @(negedge clk_i);
            ser_en_o = 1'b1;
            for (i = 0; i < n; i = i + 1) begin
                ser_di_o = f[30-i];
                repeat (3) @(negedge clk_i);
                if (i > 6) q = {q[22:0], ser_do_i};
                ser_clk_o = 1'b1;
                repeat (2) @(negedge clk_i);
                ser_clk_o = 1'b0;
            end
            ser_en_o = 1'b0;
            // Released data line must not look like the last bit
            ser_di_o = ~ser_di_o;
            repeat (4) @(negedge clk_i);
        end
    endtask
endmodule // pavdr_host

// >>> testbench/pavdr_regs_assertions.sv
// Port assertions for the register slice, bound to its top module
`timescale 1ns/100ps
module pavdr_regs_chk #(
    parameter AUX_PINS = 3
) (
    input wire                clk_i,
    input wire                rst_b_i,
    input wire                ser_en_i,
    input wire                exact_freq_en_i,
    input wire                chip_en_i,
    input wire                aux_port_en_i,
    input wire [31:0]         gpo_sources_i,
    input wire [AUX_PINS-1:0] aux_pin_o,
    input wire [AUX_PINS-1:0] aux_pin_oe_o,
    input wire                general_output_mux_o,
    input wire                phase_sync_trig_o,
    input wire                manual_cal_o,
    input wire [4:0]          cap_switch_o,
    input wire [2:0]          subband_o,
    input wire                manual_tune_o,
    input wire                charge_pump_autoscale_o,
    input wire [5:0]          div_ratio_o,
    input wire                out_mute_o,
    input wire [1:0]          osc_output_one_gain_o,
    input wire [1:0]          osc_output_two_gain_o,
    input wire                div_stage_gain_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////////////////////////////
    a_sync_cause: assert property (phase_sync_trig_o |->
        $past(chip_en_i) && !$past(chip_en_i, 2) && $past(exact_freq_en_i)) else $error("sync pulse without cause");
    a_sync_single: assert property (phase_sync_trig_o |=> !phase_sync_trig_o)
        else $error("sync pulse longer than one cycle");
    a_mute_zero: assert property (out_mute_o |-> div_ratio_o == 6'h00) else $error("mute with ratio");
    a_div_legal: assert property (!out_mute_o |-> (div_ratio_o == 6'h01) ||
        (!div_ratio_o[0] && div_ratio_o != 6'h00 && div_ratio_o <= 6'h3e)) else $error("illegal ratio");
    a_idle_stable: assert property ((!aux_port_en_i && !ser_en_i && $stable(general_output_mux_o)) [*5]
        |-> $stable(aux_pin_o) && $stable(aux_pin_oe_o)) else $error("idle pins moved");
    a_osc_hold: assert property ((!ser_en_i) [*5] |-> $stable({manual_cal_o, cap_switch_o, subband_o,
        manual_tune_o, charge_pump_autoscale_o})) else $error("oscillator controls moved without write");
    a_gain_hold: assert property ((!ser_en_i) [*5] |-> $stable({div_ratio_o, out_mute_o,
        osc_output_one_gain_o, osc_output_two_gain_o, div_stage_gain_o})) else $error("divider moved without write");
    a_gpo_uniform: assert property ((&gpo_sources_i || ~|gpo_sources_i) |=>
        general_output_mux_o == $past(gpo_sources_i[0])) else $error("general output wrong");
    c_sync: cover property (phase_sync_trig_o);
    c_mute: cover property (out_mute_o);
    c_hiz: cover property (!aux_port_en_i && aux_pin_oe_o == '0);
endmodule // pavdr_regs_chk

bind pavdr_regs pavdr_regs_chk #(.AUX_PINS(AUX_PINS)) u_pavdr_regs_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ser_en_i(ser_en_i), .exact_freq_en_i(exact_freq_en_i),
    .chip_en_i(chip_en_i), .aux_port_en_i(aux_port_en_i), .gpo_sources_i(gpo_sources_i),
    .aux_pin_o(aux_pin_o), .aux_pin_oe_o(aux_pin_oe_o), .general_output_mux_o(general_output_mux_o),
    .phase_sync_trig_o(phase_sync_trig_o), .manual_cal_o(manual_cal_o), .cap_switch_o(cap_switch_o),
    .subband_o(subband_o), .manual_tune_o(manual_tune_o), .charge_pump_autoscale_o(charge_pump_autoscale_o),
    .div_ratio_o(div_ratio_o), .out_mute_o(out_mute_o), .osc_output_one_gain_o(osc_output_one_gain_o),
    .osc_output_two_gain_o(osc_output_two_gain_o), .div_stage_gain_o(div_stage_gain_o));

// >>> testbench/pll_aux_vco_divider_registers_tb.sv
// Self-checking testbench for the register slice
`timescale 1ns/100ps
`include "pavdr_defines.vh"
module pll_aux_vco_divider_registers_tb;
    reg         clk_i, rst_b_i, cal_error_neg_i, lock_detect_i, exact_freq_en_i, chip_en_i, aux_port_en_i;
    reg  [18:0] cal_error_mag_i;
    reg  [31:0] gpo_sources_i;
    reg  [2:0]  aux_serial_pins_i;
    wire        ser_clk, ser_en, ser_di, ser_do, lvl, general_output_mux, trig, cal, tune, asc, mute, stg;
    wire [2:0]  pin, oe, sub;
    wire [4:0]  cap;
    wire [5:0]  ratio;
    wire [1:0]  g1, g2;
    wire [23:0] seed;
    reg  [23:0] q, d;
    reg  [5:0]  r;
    integer     fails, samples_checked, i, n;

    pavdr_host u_pavdr_host (.clk_i(clk_i), .ser_do_i(ser_do), .ser_clk_o(ser_clk), .ser_en_o(ser_en),
        .ser_di_o(ser_di));
    pavdr_regs #(.AUX_PINS(3)) u_pavdr_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .ser_clk_i(ser_clk),
        .ser_en_i(ser_en), .ser_di_i(ser_di), .ser_do_o(ser_do), .cal_error_mag_i(cal_error_mag_i),
        .cal_error_neg_i(cal_error_neg_i), .lock_detect_i(lock_detect_i), .gpo_sources_i(gpo_sources_i),
        .exact_freq_en_i(exact_freq_en_i), .chip_en_i(chip_en_i), .aux_port_en_i(aux_port_en_i),
        .aux_serial_pins_i(aux_serial_pins_i), .aux_pin_o(pin), .aux_pin_oe_o(oe), .aux_level_3v3_o(lvl),
        .general_output_mux_o(general_output_mux), .phase_sync_trig_o(trig), .manual_cal_o(cal), .cap_switch_o(cap),
        .subband_o(sub), .manual_tune_o(tune), .charge_pump_autoscale_o(asc), .div_ratio_o(ratio),
        .out_mute_o(mute), .osc_output_one_gain_o(g1), .osc_output_two_gain_o(g2), .div_stage_gain_o(stg),
        .mod_seed_o(seed));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input [8*8:1] nm, input [23:0] e, input [23:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wr(input [5:0] a, input [23:0] v); u_pavdr_host.xfer(1'b0, a, v, 31, q); endtask
    task rd(input [5:0] a); u_pavdr_host.xfer(1'b1, a, 24'h0, 31, q); endtask
    task summarize;
        begin
            $display("Counts: %0d mismatches, %0d comparisons", fails, samples_checked);
            if (fails == 0 && samples_checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task t_reset;
        begin
            chk("osc_out", {1'b0, 5'h10, 3'h2, 1'b0, 1'b1}, {cal, cap, sub, tune, asc});
            chk("div_out", {1'b1, 2'h2, 2'h3, 1'b0, 6'h01}, {stg, g2, g1, mute, ratio});
            chk("seed", 24'hb29d0b, seed);
            rd(`PAVDR_A_AUX_CTRL); chk("aux_rst", 24'h000220, q);
            rd(`PAVDR_A_MAN_OSC); chk("osc_rst", 24'h0f48a0, q);
            rd(`PAVDR_A_DIV_GAIN); chk("div_rst", 24'h0006c1, q);
        end
    endtask
    task t_readback;
        begin
            rd(`PAVDR_A_CAL_ERR); chk("cal_err", {4'h0, 1'b1, 19'h5a5a5}, q);
            wr(`PAVDR_A_CAL_ERR, 24'hffffff);
            rd(`PAVDR_A_CAL_ERR); chk("cal_wr", {4'h0, 1'b1, 19'h5a5a5}, q);
            wr(`PAVDR_A_SELF_TEST, 24'h0);
            rd(`PAVDR_A_SELF_TEST); chk("selftst", 24'h001259, q);
            rd(`PAVDR_A_OUT_LOCK); chk("lock", 24'h000003, q);
            gpo_sources_i = 32'h00000004;
            wr(`PAVDR_A_GPO_SEL, 24'h000002);
            rd(`PAVDR_A_OUT_LOCK); chk("gpo_sel", 24'h000003, q);
            wr(`PAVDR_A_GPO_SEL, 24'h000001);
            rd(`PAVDR_A_OUT_LOCK); chk("gpo_off", 24'h000002, q);
            gpo_sources_i = 32'hffffffff;
            rd(6'h20); chk("unmap", 24'h0, q);
        end
    endtask
    task t_static;
        begin
            wr(`PAVDR_A_AUX_CTRL, 24'h00021a);
            chk("static", {1'b1, 3'h7, 3'h5}, {lvl, oe, pin});
            wr(`PAVDR_A_AUX_CTRL, 24'h00021b);
            chk("serial", {1'b0, 3'h2}, {lvl, pin});
        end
    endtask
    task t_route;
        for (i = 1; i < 4; i = i + 1) begin
            wr(`PAVDR_A_AUX_CTRL, 24'h000200 | (i << 10));
            chk("route", 3'h1 << (i - 1), pin);
        end
    endtask
    task t_idle;
        for (i = 0; i < 4; i = i + 1) begin
            wr(`PAVDR_A_AUX_CTRL, 24'h000206 | (i << 12));
            aux_port_en_i = 1'b0;
            repeat (6) @(negedge clk_i);
            chk("idle_oe", (i == 0) ? 3'h0 : 3'h7, oe);
            if (i != 0) chk("idle_pin", (i == 1) ? 3'h3 : (i == 2) ? 3'h7 : 3'h0, pin);
            aux_port_en_i = 1'b1;
        end
    endtask
    task t_sync;
        for (i = 0; i < 3; i = i + 1) begin
            if (i == 2) wr(`PAVDR_A_AUX_CTRL, 24'h000000);
            exact_freq_en_i = (i != 0);
            chip_en_i = 1'b1;
            n = 0;
            repeat (4) @(negedge clk_i) n = n + trig;
            chk("sync", (i == 1), n);
            chip_en_i = 1'b0;
            @(negedge clk_i);
        end
    endtask
    task t_div;
        for (i = 0; i < 7; i = i + 1) begin
            r = {6'd0, 6'd1, 6'd2, 6'd3, 6'd61, 6'd62, 6'd63} >> (6 * (6 - i));
            d = {i[0], i[1:0], ~i[1:0], r};
            wr(`PAVDR_A_DIV_GAIN, d);
            chk("ratio", (r == 0) ? 0 : (r == 1) ? 1 : (r > 62) ? 62 : {r[5:1], 1'b0}, ratio);
            chk("gains", {d[10:6], r == 0}, {stg, g2, g1, mute});
            rd(`PAVDR_A_DIV_GAIN); chk("div_rd", d, q);
        end
    endtask
    task t_osc;
        begin
            wr(`PAVDR_A_MAN_OSC, 24'h004b4f);
            chk("osc_set", {1'b1, 5'h07, 3'h5, 1'b1, 1'b0}, {cal, cap, sub, tune, asc});
            rd(`PAVDR_A_MAN_OSC); chk("osc_rd", 24'h004b4f, q);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        samples_checked = 0;
        rst_b_i = 1'b0;
        cal_error_mag_i = 19'h5a5a5;
        cal_error_neg_i = 1'b1;
        lock_detect_i = 1'b1;
        gpo_sources_i = 32'hffffffff;
        exact_freq_en_i = 1'b0;
        chip_en_i = 1'b0;
        aux_port_en_i = 1'b1;
        aux_serial_pins_i = 3'h2;
        repeat (5) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (2) @(negedge clk_i);
        t_reset;
        t_readback;
        t_static;
        t_route;
        t_idle;
        t_sync;
        t_div;
        t_osc;
        summarize;
    end
    initial begin
        #500000;
        fails = fails + 1;
        summarize;
    end
endmodule // pll_aux_vco_divider_registers_tb
